//--- xlat_check_pkg.sv
// package of constants for the translated-request fault checker
// assumes a single 125 MHz clock domain and an APB register port
package xlat_check_pkg;

  // address type encodings of the request header
  localparam logic [1:0] ADDR_TYPE_UNTRANSLATED = 2'h0;
  localparam logic [1:0] ADDR_TYPE_XLAT_REQUEST = 2'h1;
  localparam logic [1:0] ADDR_TYPE_TRANSLATED   = 2'h2;

  // fault reason codes
  localparam logic [7:0] FR_NONE          = 8'h00;
  localparam logic [7:0] FR_ROOT_ABSENT   = 8'h01;
  localparam logic [7:0] FR_CTX_ABSENT    = 8'h02;
  localparam logic [7:0] FR_CTX_BADPROG   = 8'h03;
  localparam logic [7:0] FR_ROOT_FETCH    = 8'h08;
  localparam logic [7:0] FR_CTX_FETCH     = 8'h09;
  localparam logic [7:0] FR_ROOT_RSVD     = 8'h0a;
  localparam logic [7:0] FR_CTX_RSVD      = 8'h0b;
  localparam logic [7:0] FR_CTX_BLOCKED   = 8'h0d;

  // translation type encodings that pass requests without a process id
  localparam logic [1:0] TT_LEGACY_PASS   = 2'h1;
  localparam logic [2:0] TT_EXT_PASS_A    = 3'h1;
  localparam logic [2:0] TT_EXT_PASS_B    = 3'h5;

  // interrupt window: address bits 31:20, upper 32 bits zero
  localparam logic [11:0] IRQ_WINDOW_TAG  = 12'hfee;

  // completion status codes
  localparam logic [1:0] CPL_SUCCESS      = 2'h0;
  localparam logic [1:0] CPL_UNSUPPORTED  = 2'h1;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL         = 8'h00;
  localparam logic [7:0] OFS_STATUS       = 8'h04;
  localparam logic [7:0] OFS_MASK         = 8'h08;
  localparam logic [7:0] OFS_LAST_FAULT   = 8'h0c;
  localparam logic [7:0] OFS_FAULT_COUNT  = 8'h10;

  // reset values
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;

  // supported address width codes, one bit per code (arbitrary choice)
  localparam logic [7:0] AW_SUPPORTED     = 8'h0e;

  // status bit positions
  localparam int STS_NRFAULT   = 0;
  localparam int STS_GRANT_LIM = 1;
  localparam int STS_IRQ_WIN   = 2;

  // latency of the check pipeline, cycles from request to answer
  localparam int CHECK_LATENCY = 1;

endpackage

//--- fault_counter.sv
// saturating event counter for raised non-recoverable faults
// assumes pulses arrive on clk and clear comes from the register block
module fault_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // events
  input  wire logic        evt,
  input  wire logic        clr,
  // count
  output logic [15:0]      count
);

  logic [15:0] count_ff; // running total

  // a clear with an event loads one so no fault goes uncounted
  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= 16'h0000;
    end else if (evt) begin
      count_ff <= (clr) ? 16'h0001 : ((&count_ff) ? count_ff : count_ff + 16'h0001);
    end else if (clr) begin
      count_ff <= 16'h0000;
    end
  end

  assign count = count_ff;

endmodule

//--- apb_regs.sv
// apb slave for control, sticky status, mask and fault readback
// assumes zero-wait answers; unmapped reads return zero, pslverr set
module apb_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // block side
  input  wire logic [2:0]  events,
  input  wire logic [7:0]  lastFault,
  input  wire logic [15:0] faultCount,
  output logic             enable,
  output logic             cntClr,
  output logic             irq
);

  logic [31:0] ctrl_ff;   // bit0 checker enable
  logic [2:0]  status_ff; // sticky events
  logic [2:0]  mask_ff;   // interrupt enables
  logic [31:0] prdata_ff; // registered read data
  logic        pslverr_ff;
  logic        irq_ff;
  logic        clr_ff;
  logic        wr;
  logic        mapped;

  assign wr = psel & penable & pwrite;
  assign mapped = (paddr == xlat_check_pkg::OFS_CTRL) | (paddr == xlat_check_pkg::OFS_STATUS) |
                  (paddr == xlat_check_pkg::OFS_MASK) | (paddr == xlat_check_pkg::OFS_LAST_FAULT) |
                  (paddr == xlat_check_pkg::OFS_FAULT_COUNT);

  // control and mask writes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= xlat_check_pkg::CTRL_RESET;
      mask_ff <= xlat_check_pkg::MASK_RESET[2:0];
      clr_ff  <= 1'b0;
    end else begin
      clr_ff <= wr & (paddr == xlat_check_pkg::OFS_FAULT_COUNT);
      if (wr && paddr == xlat_check_pkg::OFS_CTRL) begin
        ctrl_ff <= {31'h0, pwdata[0]};
      end
      if (wr && paddr == xlat_check_pkg::OFS_MASK) begin
        mask_ff <= pwdata[2:0];
      end
    end
  end

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      status_ff <= 3'h0;
    end else if (wr && paddr == xlat_check_pkg::OFS_STATUS) begin
      status_ff <= (status_ff & ~pwdata[2:0]) | events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  // read mux and answer; access phase always completes in one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        unique case (paddr)
          xlat_check_pkg::OFS_CTRL:        prdata_ff <= ctrl_ff;
          xlat_check_pkg::OFS_STATUS:      prdata_ff <= {29'h0, status_ff};
          xlat_check_pkg::OFS_MASK:        prdata_ff <= {29'h0, mask_ff};
          xlat_check_pkg::OFS_LAST_FAULT:  prdata_ff <= {24'h0, lastFault};
          xlat_check_pkg::OFS_FAULT_COUNT: prdata_ff <= {16'h0, faultCount};
          default:                         prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |((status_ff | events) & mask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = pslverr_ff; // loaded at setup, so it stands in the access phase
  assign enable  = ctrl_ff[0];
  assign cntClr  = clr_ff;
  assign irq     = irq_ff;

endmodule

//--- xlat_fault_check.sv
// top of the translated-request fault checker
// assumes table-walk results arrive with the request from an upstream walker
//
// Notes on behaviour
// - address type 10b means already translated
// - root absent gives reason 1h, non-qualified
// - context absent gives reason 2h
// - bad context programming gives qualified 3h
// - bad width, mismatch, unsupported type give 3h
// - root fetch error gives reason 8h
// - context fetch error gives non-qualified 9h
// - root reserved bits nonzero give Ah
// - context reserved bits nonzero give Bh
// - blocking translation type gives qualified Dh
// - device caches use only successful completions
// - recoverable translation faults answer success, limited
// - interrupt window grants write and untranslated only
module xlat_fault_check (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // incoming request with its walk results
  input  wire logic        reqValid,
  input  wire logic [1:0]  addressTypeField,
  input  wire logic [63:0] reqAddr,
  input  wire logic        extendedMode,
  input  wire logic        rootFetchErr,
  input  wire logic        rootPresent,
  input  wire logic        lowerHalfPresentBit,
  input  wire logic        upperHalfPresentBit,
  input  wire logic        rootRsvdNonzero,
  input  wire logic        ctxFetchErr,
  input  wire logic        ctxPresent,
  input  wire logic        ctxRsvdNonzero,
  input  wire logic [2:0]  ctxTransType,
  input  wire logic [2:0]  addressWidthField,
  input  wire logic        recoverableCond,
  // answer
  output logic             cplValid,
  output logic [1:0]      cplStatus,
  output logic             fwdValid,
  output logic [63:0]      fwdAddr,
  output logic             faultValid,
  output logic [7:0]       faultReason,
  output logic             faultQualified,
  output logic             xlatValid,
  output logic [3:0]       xlatPerm,
  output logic             irq
);

  // check stage signals
  logic        enable;       // checker enable from control
  logic        cntClr;       // counter clear pulse
  logic [15:0] faultCount;   // running fault total
  logic [7:0]  reason;       // combinational reason
  logic        qualified;    // combinational qualified attribute
  logic        isTranslated; // request carries a host address
  logic        isXlatReq;    // request asks for a translation
  logic        inIrqWindow;  // address within the interrupt window
  logic        badProg;      // invalid context programming
  logic        blocked;      // context blocks requests without process id
  logic        rootAbsent;   // root not present; in extended mode neither half present
  logic [2:0]  events;       // status events

  logic        cplValid_ff;
  logic [1:0]  cplStatus_ff;
  logic        fwdValid_ff;
  logic [63:0] fwdAddr_ff;
  logic        faultValid_ff;
  logic [7:0]  faultReason_ff;
  logic        faultQual_ff;
  logic        xlatValid_ff;
  logic [3:0]  xlatPerm_ff;
  logic [7:0]  lastFault_ff;  // most recent reason for readback

  // request class decode
  assign isTranslated = reqValid & enable &
                        (addressTypeField == xlat_check_pkg::ADDR_TYPE_TRANSLATED);
  assign isXlatReq    = reqValid & enable &
                        (addressTypeField == xlat_check_pkg::ADDR_TYPE_XLAT_REQUEST);
  assign inIrqWindow  = (reqAddr[31:20] == xlat_check_pkg::IRQ_WINDOW_TAG) &
                        (reqAddr[63:32] == 32'h0000_0000);

  // in extended mode either half present counts, else the single bit
  assign rootAbsent = extendedMode ? ~(lowerHalfPresentBit | upperHalfPresentBit)
                                   : ~rootPresent;

  // width unsupported or type not implemented; type 3 / 7 never exist, width
  // code 1 is inconsistent with type 2
  assign badProg = ~xlat_check_pkg::AW_SUPPORTED[addressWidthField] |
                   (extendedMode ? (ctxTransType == 3'h3 || ctxTransType == 3'h7)
                                 : (ctxTransType[2] | (ctxTransType[1:0] == 2'h3))) |
                   ((ctxTransType[1:0] == 2'h2) & (addressWidthField == 3'h1));

  assign blocked = extendedMode ?
                   (ctxTransType != xlat_check_pkg::TT_EXT_PASS_A &&
                    ctxTransType != xlat_check_pkg::TT_EXT_PASS_B)
                 : (ctxTransType[1:0] != xlat_check_pkg::TT_LEGACY_PASS);

  // priority follows walk order: root fetch, root entry, context fetch,
  // context entry; the first failing step hides the later ones
  always_comb begin
    reason    = xlat_check_pkg::FR_NONE;
    qualified = 1'b0;
    if (rootFetchErr) begin
      reason = xlat_check_pkg::FR_ROOT_FETCH;
    end else if (rootAbsent) begin
      reason = xlat_check_pkg::FR_ROOT_ABSENT;
    end else if (rootRsvdNonzero) begin
      reason = xlat_check_pkg::FR_ROOT_RSVD;
    end else if (ctxFetchErr) begin
      reason = xlat_check_pkg::FR_CTX_FETCH;
    end else if (!ctxPresent) begin
      reason = xlat_check_pkg::FR_CTX_ABSENT;
    end else if (ctxRsvdNonzero) begin
      reason = xlat_check_pkg::FR_CTX_RSVD;
    end else if (badProg) begin
      reason    = xlat_check_pkg::FR_CTX_BADPROG;
      qualified = 1'b1;
    end else if (blocked) begin
      reason    = xlat_check_pkg::FR_CTX_BLOCKED;
      qualified = 1'b1;
    end
  end

  // completion path: fault gives unsupported request and no forward
  always_ff @(posedge clk) begin
    if (srst) begin
      cplValid_ff  <= 1'b0;
      cplStatus_ff <= xlat_check_pkg::CPL_SUCCESS;
      fwdValid_ff  <= 1'b0;
      fwdAddr_ff   <= 64'h0;
    end else begin
      cplValid_ff  <= (isTranslated & (reason != xlat_check_pkg::FR_NONE)) | isXlatReq;
      cplStatus_ff <= (isTranslated && reason != xlat_check_pkg::FR_NONE) ?
                      xlat_check_pkg::CPL_UNSUPPORTED : xlat_check_pkg::CPL_SUCCESS;
      fwdValid_ff  <= isTranslated & (reason == xlat_check_pkg::FR_NONE);
      fwdAddr_ff   <= reqAddr;
    end
  end

  // fault report path, one pulse per faulting translated request
  always_ff @(posedge clk) begin
    if (srst) begin
      faultValid_ff  <= 1'b0;
      faultReason_ff <= xlat_check_pkg::FR_NONE;
      faultQual_ff   <= 1'b0;
      lastFault_ff   <= xlat_check_pkg::FR_NONE;
    end else begin
      faultValid_ff <= isTranslated & (reason != xlat_check_pkg::FR_NONE);
      if (isTranslated && reason != xlat_check_pkg::FR_NONE) begin
        faultReason_ff <= reason;
        faultQual_ff   <= qualified;
        lastFault_ff   <= reason;
      end
    end
  end

  // translation completions: permissions {read, write, untranslated, priv};
  // recoverable conditions never raise a fault; outside the interrupt window they grant nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      xlatValid_ff <= 1'b0;
      xlatPerm_ff  <= 4'h0;
    end else begin
      xlatValid_ff <= isXlatReq;
      if (isXlatReq) begin
        if (inIrqWindow) begin
          xlatPerm_ff <= 4'h6;
        end else if (recoverableCond) begin
          xlatPerm_ff <= 4'h0;
        end else begin
          xlatPerm_ff <= 4'he;
        end
      end
    end
  end

  assign events = {isXlatReq & inIrqWindow,
                   isXlatReq & recoverableCond & ~inIrqWindow,
                   isTranslated & (reason != xlat_check_pkg::FR_NONE)};

  // register block
  apb_regs u_regs (
    .clk        (clk),
    .srst       (srst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .events     (events),
    .lastFault  (lastFault_ff),
    .faultCount (faultCount),
    .enable     (enable),
    .cntClr     (cntClr),
    .irq        (irq)
  );

  // fault total
  fault_counter u_cnt (
    .clk   (clk),
    .srst  (srst),
    .evt   (events[0]),
    .clr   (cntClr),
    .count (faultCount)
  );

  assign cplValid       = cplValid_ff;
  assign cplStatus      = cplStatus_ff;
  assign fwdValid       = fwdValid_ff;
  assign fwdAddr        = fwdAddr_ff;
  assign faultValid     = faultValid_ff;
  assign faultReason    = faultReason_ff;
  assign faultQualified = faultQual_ff;
  assign xlatValid      = xlatValid_ff;
  assign xlatPerm       = xlatPerm_ff;

  // a root fetch error on a translated request is reported as 8h
  AST_ROOT_FETCH: assert property (@(posedge clk) disable iff (srst)
    isTranslated && rootFetchErr |=> faultValid && faultReason == 8'h08 && !faultQualified)
    else $error("root fetch error not reported as 8h");

  // root absent without fetch error gives 1h
  AST_ROOT_ABSENT: assert property (@(posedge clk) disable iff (srst)
    isTranslated && !rootFetchErr && rootAbsent |=> faultReason == 8'h01 && faultValid)
    else $error("absent root not reported as 1h");

  // context reserved bits give Bh when earlier steps pass
  AST_CTX_RSVD: assert property (@(posedge clk) disable iff (srst)
    isTranslated && !rootFetchErr && !rootAbsent && !rootRsvdNonzero && !ctxFetchErr &&
    ctxPresent && ctxRsvdNonzero |=> faultReason == 8'h0b)
    else $error("context reserved fault not Bh");

  // blocking type alone gives qualified Dh
  AST_BLOCKED: assert property (@(posedge clk) disable iff (srst)
    isTranslated && reason == 8'h0d |=> faultValid && faultQualified && faultReason == 8'h0d)
    else $error("blocking context not qualified Dh");

  // faulting translated request completes unsupported and is not forwarded
  AST_UR_NOFWD: assert property (@(posedge clk) disable iff (srst)
    faultValid |-> cplValid && cplStatus == 2'h1 && !fwdValid)
    else $error("faulted request forwarded or not unsupported");

  // clean translated request is forwarded with its address
  AST_FWD_CLEAN: assert property (@(posedge clk) disable iff (srst)
    isTranslated && reason == 8'h00 |=> fwdValid && fwdAddr == $past(reqAddr) && !cplValid)
    else $error("clean translated request not forwarded");

  // recoverable conditions answer success with no permissions and no fault
  AST_RECOVERABLE: assert property (@(posedge clk) disable iff (srst)
    isXlatReq && recoverableCond && !inIrqWindow |=>
    xlatValid && xlatPerm == 4'h0 && cplStatus == 2'h0 && !faultValid)
    else $error("recoverable condition not a limited success");

  // interrupt window grants write and untranslated only
  AST_IRQ_WINDOW: assert property (@(posedge clk) disable iff (srst)
    isXlatReq && inIrqWindow |=> xlatValid && cplValid && xlatPerm == 4'h6)
    else $error("interrupt window grant wrong");

  // bad programming outranks blocking and is qualified 3h
  AST_BADPROG: assert property (@(posedge clk) disable iff (srst)
    isTranslated && reason == 8'h03 |=> faultQualified && faultReason == 8'h03)
    else $error("invalid programming not qualified 3h");

endmodule

//--- endpoint_model.sv
// endpoint model holding a one-entry device translation cache
// assumes completions from the checker are one-cycle pulses on clk
module endpoint_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // completion from the checker
  input  wire logic       cplValid,
  input  wire logic [1:0] cplStatus,
  input  wire logic       xlatValid,
  input  wire logic [3:0] xlatPerm,
  // cache state
  output logic            cacheValid,
  output logic [3:0]      cachePerm,
  output logic            tlbFault,
  output logic [7:0]      pageReqCount
);
  logic okCpl; // successful translation completion seen this cycle
  assign okCpl = xlatValid && cplValid && cplStatus == xlat_check_pkg::CPL_SUCCESS;

  // cache fill: a failed completion must never be cached
  always_ff @(posedge clk) begin
    if (srst) begin
      cacheValid <= 1'b0;
      cachePerm  <= 4'h0;
    end else if (okCpl) begin
      cacheValid <= 1'b1;
      cachePerm  <= xlatPerm;
    end
  end

  // a grant without read right faults at the cache; treated as recoverable,
  // reported once, and replay is left to the device
  always_ff @(posedge clk) begin
    if (srst) begin
      tlbFault     <= 1'b0;
      pageReqCount <= 8'h00;
    end else if (okCpl) begin
      tlbFault <= ~xlatPerm[3];
      if (!xlatPerm[3]) begin
        pageReqCount <= pageReqCount + 8'h01;
      end
    end
  end
endmodule

//--- xlat_fault_check_tb.sv
// self-checking bench for the translated-request fault checker
// assumes one-cycle answers on the request path and a zero-wait apb slave
module xlat_fault_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and apb master
  logic        clk = 0, srst = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq;
  // request side; walk = {rootErr,rootP,lowP,upP,rootRsvd,ctxErr,ctxP,ctxRsvd}
  logic        reqValid = 0, extendedMode = 0, recoverableCond = 0;
  logic [1:0]  addressTypeField = 2'h0, cplStatus;
  logic [63:0] reqAddr = 64'h0, fwdAddr;
  logic [7:0]  walk = 8'h00, faultReason, pageReqCount;
  logic [2:0]  ctxTransType = 3'h0, addressWidthField = 3'h0;
  logic        cplValid, fwdValid, faultValid, faultQualified, xlatValid;
  logic [3:0]  xlatPerm, cachePerm;
  logic        cacheValid, tlbFault;
  int          mismatches = 0, checks_done = 0;
  localparam logic [7:0] WALK_OK = 8'h72; // every walk step present and clean

  always #4 clk = ~clk;

  xlat_fault_check dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqValid(reqValid), .addressTypeField(addressTypeField),
    .reqAddr(reqAddr), .extendedMode(extendedMode), .rootFetchErr(walk[7]),
    .rootPresent(walk[6]), .lowerHalfPresentBit(walk[5]), .upperHalfPresentBit(walk[4]),
    .rootRsvdNonzero(walk[3]), .ctxFetchErr(walk[2]), .ctxPresent(walk[1]),
    .ctxRsvdNonzero(walk[0]), .ctxTransType(ctxTransType),
    .addressWidthField(addressWidthField), .recoverableCond(recoverableCond),
    .cplValid(cplValid), .cplStatus(cplStatus), .fwdValid(fwdValid), .fwdAddr(fwdAddr),
    .faultValid(faultValid), .faultReason(faultReason), .faultQualified(faultQualified),
    .xlatValid(xlatValid), .xlatPerm(xlatPerm), .irq(irq));

  endpoint_model ep_u (.clk(clk), .srst(srst), .cplValid(cplValid), .cplStatus(cplStatus),
    .xlatValid(xlatValid), .xlatPerm(xlatPerm), .cacheValid(cacheValid),
    .cachePerm(cachePerm), .tlbFault(tlbFault), .pageReqCount(pageReqCount));

  // one comparison; an unknown never matches
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one request pulse; the answer is sampled a cycle later, once settled
  task automatic send(input logic [1:0] at, input logic [63:0] a, input logic x,
                      input logic [7:0] w, input logic [2:0] t, input logic [2:0] aw,
                      input logic r);
    @(posedge clk);
    reqValid          <= 1'b1;
    addressTypeField  <= at;
    reqAddr           <= a;
    extendedMode      <= x;
    walk              <= w;
    ctxTransType      <= t;
    addressWidthField <= aw;
    recoverableCond   <= r;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
  endtask

  // translated request expected to fault
  task automatic fault(input logic x, input logic [7:0] w, input logic [2:0] t,
                       input logic [2:0] aw, input logic [7:0] fr, input logic q);
    send(2'h2, 64'h1000, x, w, t, aw, 1'b0);
    check(faultValid, 1'b1, "fault raised");
    check(faultReason, fr, "reason");
    check(faultQualified, q, "qualified");
    check(cplStatus, xlat_check_pkg::CPL_UNSUPPORTED, "ur status");
    check(fwdValid, 1'b0, "not forwarded");
  endtask

  // translation request expected to be granted with perm p
  task automatic xlat(input logic [63:0] a, input logic r, input logic [3:0] p);
    send(2'h1, a, 1'b0, WALK_OK, 3'h1, 3'h2, r);
    check({xlatValid, cplValid}, 2'h3, "grant");
    check(cplStatus, xlat_check_pkg::CPL_SUCCESS, "grant ok");
    check(xlatPerm, p, "perm");
    check(faultValid, 1'b0, "no nr fault");
    @(posedge clk);
    #1;
    check({cacheValid, cachePerm}, {1'b1, p}, "cache fill");
    check(tlbFault, !p[3], "cache fault");
  endtask

  // register reset values and an unmapped access
  task automatic test_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, xlat_check_pkg::OFS_CTRL, 32'h0, q, e);
    check(q, xlat_check_pkg::CTRL_RESET, "ctrl reset");
    apb(1'b0, xlat_check_pkg::OFS_MASK, 32'h0, q, e);
    check(q, xlat_check_pkg::MASK_RESET, "mask reset");
    apb(1'b0, 8'h20, 32'h0, q, e);
    check({q, e}, 33'h1, "unmapped read");
  endtask

  // every fault reason, priority first
  task automatic test_faults();
    fault(1'b0, 8'hf0, 3'h1, 3'h2, 8'h08, 1'b0);
    fault(1'b0, 8'h32, 3'h1, 3'h2, 8'h01, 1'b0);
    fault(1'b1, 8'h42, 3'h1, 3'h2, 8'h01, 1'b0);
    fault(1'b0, 8'h7a, 3'h1, 3'h2, 8'h0a, 1'b0);
    fault(1'b0, 8'h76, 3'h1, 3'h2, 8'h09, 1'b0);
    fault(1'b0, 8'h70, 3'h1, 3'h2, 8'h02, 1'b0);
    fault(1'b0, 8'h73, 3'h1, 3'h2, 8'h0b, 1'b0);
    fault(1'b0, WALK_OK, 3'h1, 3'h0, 8'h03, 1'b1);
    fault(1'b0, WALK_OK, 3'h3, 3'h2, 8'h03, 1'b1);
    fault(1'b1, WALK_OK, 3'h7, 3'h2, 8'h03, 1'b1);
    fault(1'b0, WALK_OK, 3'h0, 3'h2, 8'h0d, 1'b1);
    fault(1'b1, WALK_OK, 3'h2, 3'h2, 8'h0d, 1'b1);
  endtask

  // clean translated requests pass, untranslated ones are ignored
  task automatic test_forward();
    send(2'h2, 64'h0000_0012_3456_7000, 1'b0, WALK_OK, 3'h1, 3'h2, 1'b0);
    check({fwdValid, faultValid, cplValid}, 3'h4, "forward");
    check(fwdAddr, 64'h0000_0012_3456_7000, "fwd addr");
    send(2'h2, 64'h2000, 1'b1, WALK_OK, 3'h5, 3'h2, 1'b0);
    check({fwdValid, faultValid}, 2'h2, "ext forward");
    send(2'h0, 64'h3000, 1'b0, 8'h80, 3'h1, 3'h2, 1'b0);
    check({fwdValid, faultValid, cplValid}, 3'h0, "untranslated");
  endtask

  // translation requests: window, recoverable and plain
  task automatic test_xlat();
    xlat(64'h0000_0000_fee0_0040, 1'b0, 4'h6);
    xlat(64'h0000_0000_4000_0000, 1'b1, 4'h0);
    xlat(64'h0000_0000_4000_0000, 1'b0, 4'he);
    check(pageReqCount, 8'h02, "page requests");
  endtask

  // mask bits enable irq (reset 0); clearing status drops it; counter saw 12 faults
  task automatic test_irq();
    logic [31:0] q;
    logic e;
    check(irq, 1'b0, "irq disabled at reset");
    apb(1'b0, xlat_check_pkg::OFS_FAULT_COUNT, 32'h0, q, e);
    check(q, 32'd12, "fault count");
    apb(1'b1, xlat_check_pkg::OFS_MASK, 32'h7, q, e);
    repeat (2) @(posedge clk);
    check(irq, 1'b1, "irq up");
    apb(1'b1, xlat_check_pkg::OFS_STATUS, 32'h7, q, e);
    apb(1'b0, xlat_check_pkg::OFS_STATUS, 32'h0, q, e);
    check(q[2:0], 3'h0, "status cleared");
    check(irq, 1'b0, "irq cleared");
    apb(1'b1, xlat_check_pkg::OFS_MASK, 32'h0, q, e);
    apb(1'b1, xlat_check_pkg::OFS_FAULT_COUNT, 32'h0, q, e);
    apb(1'b0, xlat_check_pkg::OFS_FAULT_COUNT, 32'h0, q, e);
    check(q, 32'h0, "count cleared");
  endtask

  // a disabled checker answers nothing
  task automatic test_disable();
    logic [31:0] q;
    logic e;
    apb(1'b1, xlat_check_pkg::OFS_CTRL, 32'h0, q, e);
    send(2'h2, 64'h1000, 1'b0, 8'hf0, 3'h1, 3'h2, 1'b0);
    check({faultValid, cplValid, fwdValid}, 3'h0, "disabled");
    apb(1'b1, xlat_check_pkg::OFS_CTRL, 32'h1, q, e);
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence after a 10-cycle reset
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_faults();
    test_forward();
    test_xlat();
    test_irq();
    test_disable();
    final_report();
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule
